// [dv/omv_monitor.sv]
// Assertion checker for the output mux and volume block.
// Bound to omv_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module omv_monitor #(
  parameter int TIMEOUT_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [omv_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [omv_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [omv_pkg::BE_W-1:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic [omv_pkg::NUM_CH-1:0] out_sign_i,
  input wire logic hp_left_bypass_sel_o,
  input wire logic hp_right_bypass_sel_o,
  input wire logic line_left_bypass_sel_o,
  input wire logic line_right_bypass_sel_o,
  input wire logic hp_left_mute_o,
  input wire logic hp_right_mute_o,
  input wire logic line_left_mute_o,
  input wire logic [omv_pkg::GAIN_W-1:0] hp_left_gain_o,
  input wire logic [omv_pkg::GAIN_W-1:0] hp_right_gain_o,
  input wire logic [omv_pkg::GAIN_W-1:0] line_right_gain_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Accepted write to one register with byte lanes 1 and 0 enabled
  sequence s_wr(logic [7:0] idx);
    avs_write_i && !avs_waitrequest_o && avs_address_i == {idx, 2'b00} && (&avs_byteenable_i[1:0]);
  endsequence
  sequence s_quiet;
    $stable(out_sign_i[0]) [*4];
  endsequence
  property p_rst_sel;
    $fell(rst_i) |-> !(hp_left_bypass_sel_o | hp_right_bypass_sel_o | line_left_bypass_sel_o | line_right_bypass_sel_o);
  endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("select not DAC after reset");
  property p_rst_gain;
    $fell(rst_i) |-> hp_left_gain_o == 6'h2D && hp_right_gain_o == 6'h2D && !hp_left_mute_o && !hp_right_mute_o;
  endproperty
  a_rst_gain: assert property (p_rst_gain) else $error("headphone reset state wrong");
  property p_hp_sel;
    s_wr(omv_pkg::IDX_OUTPUT_SOURCE_SEL) |=>
      hp_left_bypass_sel_o == $past(avs_writedata_i[3]) && hp_right_bypass_sel_o == $past(avs_writedata_i[2]);
  endproperty
  a_hp_sel: assert property (p_hp_sel) else $error("headphone select wrong");
  property p_line_sel;
    s_wr(omv_pkg::IDX_OUTPUT_SOURCE_SEL) |=>
      line_left_bypass_sel_o == $past(avs_writedata_i[1]) && line_right_bypass_sel_o == $past(avs_writedata_i[0]);
  endproperty
  a_line_sel: assert property (p_line_sel) else $error("line select wrong");
  property p_mute;
    s_wr(omv_pkg::IDX_HP_LEFT_VOL) |=> hp_left_mute_o == $past(avs_writedata_i[8]) && $stable(hp_right_mute_o);
  endproperty
  a_mute: assert property (p_mute) else $error("left mute wrong");
  property p_indep;
    s_wr(omv_pkg::IDX_LINE_LEFT_VOL) |=> line_left_mute_o == $past(avs_writedata_i[8]) && $stable(hp_left_mute_o);
  endproperty
  a_indep: assert property (p_indep) else $error("mute leaked across outputs");
  property p_hp_commit;
    s_wr(omv_pkg::IDX_HP_LEFT_VOL) ##0 avs_writedata_i[7:6] == 2'b10 |=> ##1
      hp_left_gain_o == $past(avs_writedata_i[5:0], 2);
  endproperty
  a_hp_commit: assert property (p_hp_commit) else $error("headphone commit wrong");
  property p_line_commit;
    s_wr(omv_pkg::IDX_LINE_RIGHT_VOL) ##0 avs_writedata_i[7:6] == 2'b10 |=> ##1
      line_right_gain_o == $past(avs_writedata_i[5:0], 2);
  endproperty
  a_line_commit: assert property (p_line_commit) else $error("line commit wrong");
  property p_zc_hold;
    s_quiet ##0 s_wr(omv_pkg::IDX_HP_LEFT_VOL) ##0 avs_writedata_i[7:6] == 2'b11 |=> $stable(hp_left_gain_o) [*2];
  endproperty
  a_zc_hold: assert property (p_zc_hold) else $error("gain moved before crossing");
endmodule
`default_nettype wire

// [dv/omv_top_tb.sv]
// Self-checking bench for the output mux and volume block.
// Drives the Avalon-MM port and polarity inputs itself.
`timescale 1ns/1ps
`default_nettype none
module omv_top_tb;
  localparam int TOC = 20;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] ad = 10'h000;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] lf = 32'h00017FC0;
  logic [3:0] be = 4'hF;
  logic [3:0] sg = 4'h0;
  logic [3:0] sel;
  logic [3:0] mu;
  logic [3:0] em;
  logic [5:0] g [4];
  logic [5:0] st [4];
  logic [5:0] ac [4];
  logic [10:0] cw [3] = '{11'h080, 11'h3BF, 11'h6B9};
  logic [1:0] j;
  logic [8:0] d;
  logic wt;
  int n_errors = 0;
  int n_checks = 0;
  omv_top #(.TIMEOUT_CYCLES(TOC)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .out_sign_i(sg), .hp_left_bypass_sel_o(sel[3]), .hp_right_bypass_sel_o(sel[2]),
    .line_left_bypass_sel_o(sel[1]), .line_right_bypass_sel_o(sel[0]),
    .hp_left_mute_o(mu[0]), .hp_right_mute_o(mu[1]), .line_left_mute_o(mu[2]), .line_right_mute_o(mu[3]),
    .hp_left_gain_o(g[0]), .hp_right_gain_o(g[1]), .line_left_gain_o(g[2]), .line_right_gain_o(g[3])
  );
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  function automatic logic [9:0] a(input logic [7:0] i);
    return {i, 2'b00};
  endfunction
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // One bus access; entered just after a rising edge
  task automatic acc(input logic w, input logic [9:0] ai, input logic [31:0] di);
    rd <= !w;
    wr <= w;
    ad <= ai;
    wd <= di;
    do @(posedge ref_clk_i); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic chk_pins();
    for (int k = 0; k < 4; k++) begin
      cmp("gain", {26'h0, ac[k]}, {26'h0, g[k]});
      cmp("mute", {31'h0, em[k]}, {31'h0, mu[k]});
    end
  endtask
  task automatic chk_reg(input logic [1:0] k);
    acc(1'b0, a(8'h39 + k), 32'h0);
    cmp("vol", {23'h0, em[k], 2'b00, st[k]}, q);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      st[k] = k < 2 ? omv_pkg::HP_GAIN_RST : omv_pkg::LINE_GAIN_RST;
      ac[k] = st[k];
    end
    em = 4'h0;
    chk_pins();
    for (int k = 0; k < 4; k++) chk_reg(k[1:0]);
    acc(1'b0, a(8'h3D), 32'h0);
    cmp("srcsel", 32'h0, q);
    for (int k = 15; k >= 0; k--) begin
      acc(1'b1, a(8'h3D), k);
      cmp("sel", k, {28'h0, sel});
    end
    for (int t = 0; t < 24; t++) begin
      lf = nx(lf);
      j = t < 3 ? cw[t][10:9] : lf[1:0];
      d = t < 3 ? cw[t][8:0] : lf[12:4] & 9'h1BF;
      st[j] = d[5:0];
      em[j] = d[8];
      if (d[7]) begin
        ac[j & 2'b10] = st[j & 2'b10];
        ac[j | 2'b01] = st[j | 2'b01];
      end
      acc(1'b1, a(8'h39 + j), {23'h0, d});
      @(posedge ref_clk_i);
      chk_pins();
      chk_reg(j);
    end
    acc(1'b0, a(8'h41), 32'h0);
    cmp("active", {2'b00, ac[3], 2'b00, ac[2], 2'b00, ac[1], 2'b00, ac[0]}, q);
    acc(1'b1, 10'h3FC, 32'h1FF);
    acc(1'b0, 10'h3FC, 32'h0);
    cmp("unmapped", 32'h0, q);
    acc(1'b0, 10'h0E5, 32'h0);
    cmp("unaligned", 32'h0, q);
    chk_pins();
    acc(1'b1, a(8'h3A), 32'h05A);
    acc(1'b1, a(8'h39), 32'h0E0);
    st[0] = 6'h20;
    st[1] = 6'h1A;
    em[1:0] = 2'b00;
    repeat (30) @(posedge ref_clk_i);
    chk_pins();
    acc(1'b0, a(8'h42), 32'h0);
    cmp("waiting", 32'h3, q);
    sg[0] <= ~sg[0];
    repeat (8) @(posedge ref_clk_i);
    ac[0] = st[0];
    chk_pins();
    acc(1'b1, a(8'h40), 32'h1);
    repeat (30) @(posedge ref_clk_i);
    ac[1] = st[1];
    chk_pins();
    complete_run();
  end
endmodule
bind omv_top omv_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (.*);
`default_nettype wire

// [rtl/omv_pkg.sv]
// Constants for the output mux and volume control block.
// Assumes a 100 MHz system clock and an Avalon-MM register slave.
package omv_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_HP_LEFT_VOL = 8'h39;
  localparam logic [7:0] IDX_HP_RIGHT_VOL = 8'h3A;
  localparam logic [7:0] IDX_LINE_LEFT_VOL = 8'h3B;
  localparam logic [7:0] IDX_LINE_RIGHT_VOL = 8'h3C;
  localparam logic [7:0] IDX_OUTPUT_SOURCE_SEL = 8'h3D;
  localparam logic [7:0] IDX_TIMEOUT_CTRL = 8'h40;
  localparam logic [7:0] IDX_ACTIVE_GAIN = 8'h41;
  localparam logic [7:0] IDX_PENDING_STATUS = 8'h42;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int GAIN_W = 6;
  localparam int NUM_CH = 4;

  // Channel numbering: headphone pair, then line pair
  localparam int CH_HP_LEFT = 0;
  localparam int CH_HP_RIGHT = 1;
  localparam int CH_LINE_LEFT = 2;
  localparam int CH_LINE_RIGHT = 3;

  // Volume register fields
  localparam int MUTE_BIT = 8;
  localparam int COMMIT_BIT = 7;
  localparam int ZC_BIT = 6;
  localparam int GAIN_LSB = 0;

  // Source select fields
  localparam int HP_LEFT_SEL_BIT = 3;
  localparam int HP_RIGHT_SEL_BIT = 2;
  localparam int LINE_LEFT_SEL_BIT = 1;
  localparam int LINE_RIGHT_SEL_BIT = 0;
  localparam logic SEL_DAC = 1'b0;

  // Timeout control field
  localparam int TIMEOUT_EN_BIT = 0;

  // Reset values
  localparam logic [5:0] HP_GAIN_RST = 6'h2D;
  localparam logic [5:0] LINE_GAIN_RST = 6'h39;

  // Zero-cross timeout
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 10000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int TIMEOUT_CNT_W = 32;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_WAIT = 2'b10
  } omv_chan_state_t;
endpackage

// [rtl/omv_top.sv]
// Output mux and volume control register bank with four gain channels.
// Assumes an Avalon-MM master on the same clock; polarity inputs are async.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Outputs default to DAC, bypass selectable
// - Bits 3/2 select headphone left/right source
// - Bits 1/0 select line left/right source
// - Each output has own volume and mute
// - Zero-cross enable delays change until crossing
// - Timeout forces change while timeout clock enabled
// - Writes without update bit change no gain, except clearing bit 6 while waiting applies the held gain
// - Headphone update bit commits both channels together
// - Bit 8 mutes channel, resets to zero
// - Bit 6 enables zero-cross, resets to zero
// - Six-bit gain, code 57 is 0dB
// - Headphone gains reset to 10_1101
// - Line update bit commits both line channels
module omv_top #(
  parameter int TIMEOUT_CYCLES = omv_pkg::TIMEOUT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [omv_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [omv_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [omv_pkg::BE_W-1:0] avs_byteenable_i,
  output logic [omv_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [omv_pkg::NUM_CH-1:0] out_sign_i,
  output logic hp_left_bypass_sel_o,
  output logic hp_right_bypass_sel_o,
  output logic line_left_bypass_sel_o,
  output logic line_right_bypass_sel_o,
  output logic hp_left_mute_o,
  output logic hp_right_mute_o,
  output logic line_left_mute_o,
  output logic line_right_mute_o,
  output logic [omv_pkg::GAIN_W-1:0] hp_left_gain_o,
  output logic [omv_pkg::GAIN_W-1:0] hp_right_gain_o,
  output logic [omv_pkg::GAIN_W-1:0] line_left_gain_o,
  output logic [omv_pkg::GAIN_W-1:0] line_right_gain_o
);
  localparam int N = omv_pkg::NUM_CH;
  localparam int GW = omv_pkg::GAIN_W;

  // Bus handshake
  logic wait_reg;
  logic [omv_pkg::DATA_W-1:0] rdata_reg;
  logic [omv_pkg::DATA_W-1:0] rdata_next;
  logic [7:0] idx;
  logic aligned;
  logic wr_fire;

  // Stored register contents
  logic [GW-1:0] pend_gain_reg [N];
  logic [N-1:0] zc_en_reg;
  logic [N-1:0] mute_reg;
  logic [3:0] src_sel_reg;
  logic timeout_clock_en_reg;

  // Commit strobes
  logic hp_volume_commit_reg;
  logic line_volume_commit_reg;
  logic hp_commit_next;
  logic line_commit_next;
  logic [N-1:0] commit;

  // Channel state
  logic [N-1:0] sign_meta_reg;
  logic [N-1:0] sign_sync_reg;
  logic [GW-1:0] active_gain [N];
  logic [N-1:0] waiting;

  assign idx = avs_address_i[omv_pkg::ADDR_W-1:2];
  assign aligned = (avs_address_i[1:0] == 2'b00);
  assign wr_fire = avs_write_i && !wait_reg;

  // One wait cycle, then the answer for one cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wait_reg <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign avs_waitrequest_o = wait_reg;

  // Read decode
  always_comb begin
    rdata_next = '0;
    if (!aligned) begin
      rdata_next = '0;
    end else if (idx >= omv_pkg::IDX_HP_LEFT_VOL && idx <= omv_pkg::IDX_LINE_RIGHT_VOL) begin
      for (int c = 0; c < N; c++) begin
        if (idx == omv_pkg::IDX_HP_LEFT_VOL + 8'(c)) begin
          rdata_next[omv_pkg::MUTE_BIT] = mute_reg[c];
          rdata_next[omv_pkg::COMMIT_BIT] = 1'b0;
          rdata_next[omv_pkg::ZC_BIT] = zc_en_reg[c];
          rdata_next[omv_pkg::GAIN_LSB +: GW] = pend_gain_reg[c];
        end
      end
    end else if (idx == omv_pkg::IDX_OUTPUT_SOURCE_SEL) begin
      rdata_next[3:0] = src_sel_reg;
    end else if (idx == omv_pkg::IDX_TIMEOUT_CTRL) begin
      rdata_next[omv_pkg::TIMEOUT_EN_BIT] = timeout_clock_en_reg;
    end else if (idx == omv_pkg::IDX_ACTIVE_GAIN) begin
      for (int c = 0; c < N; c++) begin
        rdata_next[8*c +: GW] = active_gain[c];
      end
    end else if (idx == omv_pkg::IDX_PENDING_STATUS) begin
      rdata_next[N-1:0] = waiting;
    end else begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (avs_read_i && wait_reg) begin
      rdata_reg <= rdata_next;
    end else if (!wait_reg) begin
      rdata_reg <= '0;
    end
  end

  assign avs_readdata_o = rdata_reg;

  // Per-channel volume registers
  generate
    for (genvar c = 0; c < N; c++) begin : g_vol
      logic hit;
      assign hit = wr_fire && aligned && (idx == omv_pkg::IDX_HP_LEFT_VOL + 8'(c));

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          mute_reg[c] <= 1'b0;
          zc_en_reg[c] <= 1'b0;
          pend_gain_reg[c] <= (c < omv_pkg::CH_LINE_LEFT) ? omv_pkg::HP_GAIN_RST
                                                         : omv_pkg::LINE_GAIN_RST;
        end else if (hit) begin
          if (avs_byteenable_i[1]) begin
            mute_reg[c] <= avs_writedata_i[omv_pkg::MUTE_BIT];
          end
          if (avs_byteenable_i[0]) begin
            zc_en_reg[c] <= avs_writedata_i[omv_pkg::ZC_BIT];
            pend_gain_reg[c] <= avs_writedata_i[omv_pkg::GAIN_LSB +: GW];
          end
        end
      end
    end
  endgenerate

  // Update strobes, fired the cycle after the write lands
  always_comb begin
    hp_commit_next = 1'b0;
    line_commit_next = 1'b0;
    if (wr_fire && aligned && avs_byteenable_i[0] && avs_writedata_i[omv_pkg::COMMIT_BIT]) begin
      if (idx == omv_pkg::IDX_HP_LEFT_VOL || idx == omv_pkg::IDX_HP_RIGHT_VOL) begin
        hp_commit_next = 1'b1;
      end else if (idx == omv_pkg::IDX_LINE_LEFT_VOL || idx == omv_pkg::IDX_LINE_RIGHT_VOL) begin
        line_commit_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hp_volume_commit_reg <= 1'b0;
      line_volume_commit_reg <= 1'b0;
    end else begin
      hp_volume_commit_reg <= hp_commit_next;
      line_volume_commit_reg <= line_commit_next;
    end
  end

  assign commit[omv_pkg::CH_HP_LEFT] = hp_volume_commit_reg;
  assign commit[omv_pkg::CH_HP_RIGHT] = hp_volume_commit_reg;
  assign commit[omv_pkg::CH_LINE_LEFT] = line_volume_commit_reg;
  assign commit[omv_pkg::CH_LINE_RIGHT] = line_volume_commit_reg;

  // Source select register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      src_sel_reg <= {4{omv_pkg::SEL_DAC}};
    end else if (wr_fire && aligned && avs_byteenable_i[0] && idx == omv_pkg::IDX_OUTPUT_SOURCE_SEL) begin
      src_sel_reg <= avs_writedata_i[3:0];
    end
  end

  // Timeout clock enable
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timeout_clock_en_reg <= 1'b0;
    end else if (wr_fire && aligned && avs_byteenable_i[0] && idx == omv_pkg::IDX_TIMEOUT_CTRL) begin
      timeout_clock_en_reg <= avs_writedata_i[omv_pkg::TIMEOUT_EN_BIT];
    end
  end

  // Polarity synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sign_meta_reg <= '0;
      sign_sync_reg <= '0;
    end else begin
      sign_meta_reg <= out_sign_i;
      sign_sync_reg <= sign_meta_reg;
    end
  end

  // Gain channels
  generate
    for (genvar c = 0; c < N; c++) begin : g_chan
      omv_vol_chan #(
        .RESET_GAIN((c < omv_pkg::CH_LINE_LEFT) ? omv_pkg::HP_GAIN_RST : omv_pkg::LINE_GAIN_RST),
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
      ) u_chan (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .commit_i(commit[c]),
        .pending_gain_i(pend_gain_reg[c]),
        .zero_cross_en_i(zc_en_reg[c]),
        .timeout_clock_en_i(timeout_clock_en_reg),
        .sign_i(sign_sync_reg[c]),
        .active_gain_o(active_gain[c]),
        .waiting_o(waiting[c])
      );
    end
  endgenerate

  // Analogue controls
  assign hp_left_gain_o = active_gain[omv_pkg::CH_HP_LEFT];
  assign hp_right_gain_o = active_gain[omv_pkg::CH_HP_RIGHT];
  assign line_left_gain_o = active_gain[omv_pkg::CH_LINE_LEFT];
  assign line_right_gain_o = active_gain[omv_pkg::CH_LINE_RIGHT];

  assign hp_left_mute_o = mute_reg[omv_pkg::CH_HP_LEFT];
  assign hp_right_mute_o = mute_reg[omv_pkg::CH_HP_RIGHT];
  assign line_left_mute_o = mute_reg[omv_pkg::CH_LINE_LEFT];
  assign line_right_mute_o = mute_reg[omv_pkg::CH_LINE_RIGHT];

  assign hp_left_bypass_sel_o = src_sel_reg[omv_pkg::HP_LEFT_SEL_BIT];
  assign hp_right_bypass_sel_o = src_sel_reg[omv_pkg::HP_RIGHT_SEL_BIT];
  assign line_left_bypass_sel_o = src_sel_reg[omv_pkg::LINE_LEFT_SEL_BIT];
  assign line_right_bypass_sel_o = src_sel_reg[omv_pkg::LINE_RIGHT_SEL_BIT];
endmodule
`default_nettype wire

// [rtl/omv_vol_chan.sv]
// One output channel: holds the active gain and applies committed values.
// Assumes the polarity input is already synchronised to the clock.
`timescale 1ns/1ps
`default_nettype none
module omv_vol_chan #(
  parameter logic [5:0] RESET_GAIN = 6'h00,
  parameter int TIMEOUT_CYCLES = omv_pkg::TIMEOUT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic commit_i,
  input wire logic [omv_pkg::GAIN_W-1:0] pending_gain_i,
  input wire logic zero_cross_en_i,
  input wire logic timeout_clock_en_i,
  input wire logic sign_i,
  output logic [omv_pkg::GAIN_W-1:0] active_gain_o,
  output logic waiting_o
);
  omv_pkg::omv_chan_state_t state_reg;
  logic [omv_pkg::GAIN_W-1:0] held_reg;
  logic sign_prev_reg;
  logic [omv_pkg::TIMEOUT_CNT_W-1:0] tmo_cnt_reg;
  logic crossed;
  logic timed_out;

  assign crossed = sign_i ^ sign_prev_reg;
  assign timed_out = timeout_clock_en_i && (tmo_cnt_reg >= TIMEOUT_CYCLES[omv_pkg::TIMEOUT_CNT_W-1:0] - 1'b1);

  // Sign history for crossing detection
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sign_prev_reg <= 1'b0;
    end else begin
      sign_prev_reg <= sign_i;
    end
  end

  // Pending change state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= omv_pkg::CH_IDLE;
      held_reg <= RESET_GAIN;
      active_gain_o <= RESET_GAIN;
    end else begin
      case (state_reg)
        omv_pkg::CH_IDLE: begin
          if (commit_i) begin
            held_reg <= pending_gain_i;
            if (zero_cross_en_i) begin
              state_reg <= omv_pkg::CH_WAIT;
            end else begin
              active_gain_o <= pending_gain_i;
            end
          end
        end
        omv_pkg::CH_WAIT: begin
          if (commit_i) begin
            held_reg <= pending_gain_i;
            if (!zero_cross_en_i) begin
              active_gain_o <= pending_gain_i;
              state_reg <= omv_pkg::CH_IDLE;
            end
          end else if (!zero_cross_en_i || crossed || timed_out) begin
            active_gain_o <= held_reg;
            state_reg <= omv_pkg::CH_IDLE;
          end
        end
        default: begin
          state_reg <= omv_pkg::CH_IDLE;
        end
      endcase
    end
  end

  // Timeout counter, runs only while waiting and enabled
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tmo_cnt_reg <= '0;
    end else if (state_reg != omv_pkg::CH_WAIT || commit_i || !timeout_clock_en_i) begin
      tmo_cnt_reg <= '0;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      waiting_o <= 1'b0;
    end else begin
      waiting_o <= (state_reg == omv_pkg::CH_WAIT) || (commit_i && zero_cross_en_i);
    end
  end
endmodule
`default_nettype wire
